// *** rtl/aes_status.sv ***
// Behaviour
// - Bits 17:12 give best pending enabled exception
// - Codes: 0x02 to 0x0F, 0x10+n, none above
// - External interrupts up to 29, code 0x2D
// - Return flag low if preempted handler active
// - Return flag high if none or one active
// - Return flag ignores NMI and faults
// - Bits 10:6 read zero
// - Bits 5:0 give active exception, reset 0
// - Active field zero in thread mode and for handler numbers above 0x2D
// - Active field equals handler number field up to 0x2D
`default_nettype none
module aes_status (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [aes_pkg::AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core exception state
  input wire logic [aes_pkg::VEC_W-1:0] handler_number_field_i,
  input wire logic [aes_pkg::NUM_VEC-1:0] vec_active_i,
  input wire logic [aes_pkg::NUM_VEC-1:0] vec_pending_i,
  input wire logic [aes_pkg::NUM_VEC-1:0] vec_enabled_i,
  input wire logic [aes_pkg::NUM_VEC-1:0] vec_masked_i,
  // Status out
  output logic [aes_pkg::VEC_W-1:0] active_vector_number_o,
  output logic [aes_pkg::VEC_W-1:0] pending_vector_number_o,
  output logic return_to_base_flag_o
);
  import aes_pkg::*;

  aes_vec_t act_r;
  aes_vec_t pend_r;
  logic ret_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic [NUM_VEC-1:0] cand;
  logic [NUM_VEC-1:0] ord_act;
  logic ret_nxt;
  logic [6:0] ord_cnt;
  aes_sel_if sel_bus ();

  function automatic logic is_ordinary(input int v);
    return v == int'(VEC_SVC_PEND) || v == int'(VEC_TICK) || v == int'(VEC_SVC_CALL) ||
           v == int'(VEC_DEBUG_MON) || (v >= int'(VEC_EXT_BASE) && v <= int'(VEC_MAX));
  endfunction : is_ordinary

  function automatic logic [31:0] status_word(input aes_vec_t pend, input logic ret, input aes_vec_t act);
    logic [31:0] w;
    w = UNMAPPED_DATA;
    w[PEND_MSB:PEND_LSB] = pend;
    w[RET_FLAG_BIT] = ret;
    w[ACT_MSB:ACT_LSB] = act;
    return w;
  endfunction : status_word

  // Masking by base priority and fault mask arrives folded into vec_masked_i; the global mask is not applied
  always_comb begin
    for (int i = 0; i < NUM_VEC; i++) begin
      cand[i] = vec_pending_i[i] && vec_enabled_i[i] && !vec_masked_i[i] && i >= 2 &&
                i <= int'(VEC_MAX);
      ord_act[i] = vec_active_i[i] && is_ordinary(i);
    end
  end
  assign sel_bus.cand = cand;

  aes_pick u_pick (
    .s(sel_bus.sel)
  );

  // More than one ordinary active means a preempted handler sits below
  always_comb begin
    ord_cnt = 7'($countones(ord_act));
    ret_nxt = (ord_cnt <= 7'h01);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_r <= VEC_NONE;
    end else begin
      act_r <= (handler_number_field_i > VEC_MAX) ? VEC_NONE : handler_number_field_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_r <= VEC_NONE;
    end else begin
      pend_r <= sel_bus.found ? sel_bus.pick : VEC_NONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ret_r <= 1'b1;
    end else begin
      ret_r <= ret_nxt;
    end
  end

  // Single-cycle ack; writes complete but change nothing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
    end
  end

  // Data stays zero outside the ack cycle so no stale word leaks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= UNMAPPED_DATA;
    end else begin
      dat_r <= UNMAPPED_DATA;
      if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r) begin
        unique case (wb_adr_i)
          AES_STATUS_OFF: begin
            dat_r <= status_word(pend_r, ret_r, act_r);
          end
          AES_ACTIVE_STACK_OFF: begin
            dat_r <= {26'h0, ord_cnt[5:0]};
          end
          default: begin
            dat_r <= UNMAPPED_DATA;
          end
        endcase
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign active_vector_number_o = act_r;
  assign pending_vector_number_o = pend_r;
  assign return_to_base_flag_o = ret_r;

  // Status fields
  AST_ACT_FOLLOWS: assert property (@(posedge clk_i) disable iff (rst_i)
    handler_number_field_i <= VEC_MAX |=> act_r == $past(handler_number_field_i))
    else $error("active field not tracking handler number");
  AST_THREAD_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    handler_number_field_i == VEC_NONE |=> act_r == VEC_NONE)
    else $error("active field nonzero in thread mode");
  AST_HN_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
    handler_number_field_i > VEC_MAX |=> act_r == VEC_NONE)
    else $error("active field shows a reserved code");
  AST_RESET_VALUES: assert property (@(posedge clk_i)
    rst_i |=> act_r == VEC_NONE && pend_r == VEC_NONE && ret_r && !ack_r)
    else $error("status not at reset values");
  AST_RET_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
    $countones(ord_act) >= 2 |=> !ret_r)
    else $error("return flag high with preempted handler");
  AST_RET_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
    $countones(vec_active_i & ~64'h7C) <= 1 |=> ret_r)
    else $error("return flag low with at most one ordinary active");
  AST_PEND_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
    pend_r <= VEC_MAX && act_r <= VEC_MAX)
    else $error("reported code above range");

  // Pending selection
  AST_PEND_NONE: assert property (@(posedge clk_i) disable iff (rst_i)
    cand == '0 |=> pend_r == VEC_NONE)
    else $error("pending nonzero with nothing pending");
  AST_PEND_NOT_RSVD: assert property (@(posedge clk_i) disable iff (rst_i)
    pend_r == VEC_NONE || pend_r >= VEC_NMI)
    else $error("pending field shows reserved code one");
  AST_PICK_LOWEST: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_bus.found |-> cand[sel_bus.pick] && (cand & ((64'h1 << sel_bus.pick) - 64'h1)) == 64'h0)
    else $error("picked code is not the lowest candidate");
  AST_PICK_LEGAL: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_bus.found |-> vec_pending_i[sel_bus.pick] && vec_enabled_i[sel_bus.pick] && !vec_masked_i[sel_bus.pick])
    else $error("picked code not pending, enabled and unmasked");
  AST_FOUND_ANY: assert property (@(posedge clk_i) disable iff (rst_i)
    cand != 64'h0 |-> sel_bus.found)
    else $error("candidate present but nothing picked");
  AST_EXT0: assert property (@(posedge clk_i) disable iff (rst_i)
    cand == (64'h1 << VEC_EXT_BASE) |=> pend_r == VEC_EXT_BASE)
    else $error("interrupt 0 not reported as 0x10");
  AST_EXT29: assert property (@(posedge clk_i) disable iff (rst_i)
    cand == (64'h1 << VEC_MAX) |=> pend_r == VEC_MAX)
    else $error("interrupt 29 not reported as 0x2D");

  // Bus side
  AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !ack_r |=> ack_r)
    else $error("request not answered in one cycle");
  AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_r |=> !ack_r)
    else $error("ack longer than one cycle");
  AST_DAT_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
    !ack_r |-> dat_r == UNMAPPED_DATA)
    else $error("read data nonzero outside ack");
  AST_STATUS_READ: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r && wb_adr_i == AES_STATUS_OFF |=>
    dat_r == {14'h0, $past(pend_r), $past(ret_r), 5'h00, $past(act_r)})
    else $error("status word fields misplaced");
  AST_RSVD_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_r |-> dat_r[10:6] == 5'h00)
    else $error("reserved bits nonzero");
  AST_WR_NOEFFECT: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && wb_we_i && handler_number_field_i <= VEC_MAX |=>
    dat_r == UNMAPPED_DATA && act_r == $past(handler_number_field_i))
    else $error("write altered reported state");
  AST_COUNT_READ: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r && wb_adr_i == AES_ACTIVE_STACK_OFF |=>
    dat_r == 32'($countones($past(ord_act))))
    else $error("active count readback wrong");

  // Main scenarios
  COV_NESTED: cover property (@(posedge clk_i) disable iff (rst_i) ret_r ##1 !ret_r);
  COV_PEND_EXT: cover property (@(posedge clk_i) disable iff (rst_i) pend_r >= VEC_EXT_BASE);
  COV_READ: cover property (@(posedge clk_i) disable iff (rst_i) ack_r && !wb_we_i);
  COV_WRITE: cover property (@(posedge clk_i) disable iff (rst_i) ack_r && wb_we_i);
  COV_EXT29: cover property (@(posedge clk_i) disable iff (rst_i) pend_r == VEC_MAX);
endmodule : aes_status
`default_nettype wire

// *** rtl/aes_pkg.sv ***
`default_nettype none
package aes_pkg;
  localparam int unsigned AW = 8;
  localparam logic [7:0] AES_STATUS_OFF = 8'h00;
  localparam logic [7:0] AES_ACTIVE_STACK_OFF = 8'h04;
  localparam int unsigned VEC_W = 6;
  localparam int unsigned PEND_LSB = 12;
  localparam int unsigned PEND_MSB = 17;
  localparam int unsigned RET_FLAG_BIT = 11;
  localparam int unsigned ACT_LSB = 0;
  localparam int unsigned ACT_MSB = 5;
  localparam logic [5:0] VEC_NONE = 6'h00;
  localparam logic [5:0] VEC_NMI = 6'h02;
  localparam logic [5:0] VEC_FAULT_LO = 6'h03;
  localparam logic [5:0] VEC_FAULT_HI = 6'h06;
  localparam logic [5:0] VEC_SVC_CALL = 6'h0B;
  localparam logic [5:0] VEC_DEBUG_MON = 6'h0C;
  localparam logic [5:0] VEC_SVC_PEND = 6'h0E;
  localparam logic [5:0] VEC_TICK = 6'h0F;
  localparam logic [5:0] VEC_EXT_BASE = 6'h10;
  localparam logic [5:0] VEC_MAX = 6'h2D;
  localparam int unsigned NUM_EXT = 30;
  localparam int unsigned NUM_VEC = 64;
  localparam logic [31:0] RESET_WORD = 32'h0000_0800;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  typedef logic [5:0] aes_vec_t;
endpackage : aes_pkg
`default_nettype wire

// *** rtl/aes_if.sv ***
`default_nettype none
interface aes_sel_if;
  logic [aes_pkg::NUM_VEC-1:0] cand;
  logic [5:0] pick;
  logic found;
  modport req (output cand, input pick, input found);
  modport sel (input cand, output pick, output found);
endinterface : aes_sel_if
`default_nettype wire

// *** rtl/aes_pick.sv ***
`default_nettype none
module aes_pick (
  // Candidates in, lowest code out
  aes_sel_if.sel s
);
  import aes_pkg::*;
  // Lowest code wins outright; caller only gates pending, enabled, unmasked and range, with no priority levels
  always_comb begin
    s.pick = VEC_NONE;
    s.found = 1'b0;
    for (int i = NUM_VEC - 1; i > 0; i--) begin
      if (s.cand[i] && i <= int'(VEC_MAX)) begin
        s.pick = 6'(i);
        s.found = 1'b1;
      end
    end
  end
endmodule : aes_pick
`default_nettype wire

// *** verif/active_exception_status_test.sv ***
`default_nettype none
module active_exception_status_test;
  timeunit 1ns;
  timeprecision 1ps;
  import aes_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic ack;
  logic ret_o;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rd;
  logic [31:0] dat_o;
  logic [5:0] hn = 6'h00;
  logic [5:0] act_o;
  logic [5:0] pend_o;
  logic [63:0] va = '0;
  logic [63:0] vp = '0;
  logic [63:0] ve = '0;
  logic [63:0] vm = '0;
  logic [5:0] pc [5] = '{6'h0E, 6'h0F, 6'h10, 6'h11, 6'h2D};
  int n_errors = 0;
  int n_compared = 0;
  aes_status u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .handler_number_field_i(hn), .vec_active_i(va), .vec_pending_i(vp), .vec_enabled_i(ve),
    .vec_masked_i(vm), .active_vector_number_o(act_o), .pending_vector_number_o(pend_o),
    .return_to_base_flag_o(ret_o));
  initial forever #2.5 clk_i = ~clk_i;
  task automatic summarize;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Waits on ack itself; the slave's latency is not assumed
  task automatic wb(input logic w, input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= 32'hFFFF_FFFF;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    d = dat_o;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask : wb
  // Status lags inputs by one clock, so settle two edges
  task automatic st(input logic [5:0] h, input logic [63:0] a, input logic [63:0] p, input logic [63:0] e,
    input logic [63:0] m);
    @(posedge clk_i);
    hn <= h;
    va <= a;
    vp <= p;
    ve <= e;
    vm <= m;
    repeat (2) @(posedge clk_i);
  endtask : st
  task automatic look(input logic [5:0] p, input logic r, input logic [5:0] a);
    logic [31:0] e;
    e = {14'h0000, p, r, 5'h00, a};
    wb(1'b0, 8'h00, rd);
    chk("status word", e, rd);
    chk("status ports", e, {14'h0000, pend_o, ret_o, 5'h00, act_o});
  endtask : look
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    look(6'h00, 1'b1, 6'h00);
    $display("test reset done");
    foreach (pc[i]) begin
      st(6'h00, '0, 64'h1 << pc[i], 64'h1 << pc[i], '0);
      look(pc[i], 1'b1, 6'h00);
    end
    st(6'h00, '0, 64'h1 << 6'h2E, '1, '0);
    look(6'h00, 1'b1, 6'h00);
    st(6'h00, '0, 64'h1 << 6'h10, '0, '0);
    look(6'h00, 1'b1, 6'h00);
    st(6'h00, '0, 64'h0000_2000_0000_C000, '1, 64'h0000_0000_0000_4000);
    look(6'h0F, 1'b1, 6'h00);
    $display("test pending done");
    st(6'h2D, 64'h1 << 6'h2D, '0, '0, '0);
    look(6'h00, 1'b1, 6'h2D);
    st(6'h2D, 64'h0000_2000_0001_0000, '0, '0, '0);
    look(6'h00, 1'b0, 6'h2D);
    wb(1'b0, AES_ACTIVE_STACK_OFF, rd);
    chk("active count", 32'h0000_0002, rd);
    chk("interrupt index", 32'h0000_001D, 32'(act_o - VEC_EXT_BASE));
    wb(1'b1, 8'h00, rd);
    look(6'h00, 1'b0, 6'h2D);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("reset ports", RESET_WORD, {14'h0000, pend_o, ret_o, 5'h00, act_o});
    rst_i <= 1'b0;
    look(6'h00, 1'b0, 6'h2D);
    $display("test reset again done");
    st(6'h10, 64'h0000_0000_0001_000C, '0, '0, '0);
    look(6'h00, 1'b1, 6'h10);
    st(6'h00, '0, '0, '0, '0);
    look(6'h00, 1'b1, 6'h00);
    st(6'h3F, '0, '0, '0, '0);
    look(6'h00, 1'b1, 6'h00);
    $display("test active done");
    wb(1'b0, 8'h08, rd);
    chk("unmapped read", 32'h0000_0000, rd);
    $display("test unmapped done");
    summarize();
  end
  // Whole run is near 100 cycles; a hang stops at 2000, well above this
  initial begin
    repeat (2000) @(posedge clk_i);
    n_errors++;
    summarize();
  end
endmodule : active_exception_status_test
`default_nettype wire
